// file: pkg/cap_sense_pkg.sv
// shared constants, field layouts and types for the capacitive sense post-processor
package cap_sense_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_TIME_US = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;

  // fixed bus address of the serial slave
  localparam logic [6:0] DEV_ADDR = 7'h44;

  // register indices (apb byte address = index * 4, serial pointer = index)
  localparam logic [7:0] R_SYS = 8'h00;
  localparam logic [7:0] R_EVT = 8'h01;
  localparam logic [7:0] R_PS0 = 8'h02;
  localparam logic [7:0] R_PS1 = 8'h03;
  localparam logic [7:0] R_CFG = 8'h04;
  localparam logic [7:0] R_TGT0 = 8'h05;
  localparam logic [7:0] R_TGTT = 8'h06;
  localparam logic [7:0] R_PTH = 8'h07;
  localparam logic [7:0] R_TTH1 = 8'h08;
  localparam logic [7:0] R_TTH2 = 8'h09;
  localparam logic [7:0] R_TTH3 = 8'h0A;
  localparam logic [7:0] R_BASE = 8'h0B;
  localparam logic [7:0] R_EMASK = 8'h0C;
  localparam logic [7:0] R_MULT = 8'h0D;
  localparam logic [7:0] R_VIEW = 8'h0E;
  localparam logic [7:0] R_BLH = 8'h0F;
  localparam logic [7:0] R_BLL = 8'h10;
  localparam logic [7:0] R_CNTH = 8'h11;
  localparam logic [7:0] R_CNTL = 8'h12;
  localparam logic [7:0] REG_COUNT = 8'h13;

  // field positions
  localparam int unsigned SYS_BUSY = 0;
  localparam int unsigned SYS_NOISE = 1;
  localparam int unsigned SYS_PROJ = 2;
  localparam int unsigned SYS_RESET = 7;
  localparam int unsigned PS0_SHOW_RESET = 7;
  localparam int unsigned PS0_ACK_RESET = 6;
  localparam int unsigned PS0_REDO = 4;
  localparam int unsigned PS0_PARTIAL = 3;
  localparam int unsigned PS1_WDT_OFF = 7;
  localparam int unsigned PS1_EVT_OFF = 6;
  localparam int unsigned PS1_TUNE_OFF = 1;
  localparam int unsigned PS1_NOISE_EN = 0;
  localparam logic [7:0] PS0_WMASK = 8'h18;
  localparam logic [7:0] PS1_WMASK = 8'hC3;

  // reset values
  localparam logic [7:0] PS0_RST = 8'h00;
  localparam logic [7:0] PS1_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] TGT0_RST = 8'h28;
  localparam logic [7:0] TGTT_RST = 8'h40;
  localparam logic [7:0] PTH_RST = 8'h08;
  localparam logic [7:0] TTH_RST = 8'h10;
  localparam logic [7:0] BASE_RST = 8'h60;
  localparam logic [3:0] EMASK_RST = 4'hF;
  localparam logic [3:0] MULT_RST = 4'h4;

  // filter and tuning arithmetic
  localparam int unsigned FILTER_SHIFT = 4;
  localparam int unsigned TARGET_SHIFT = 3;
  localparam int unsigned RETUNE_SHIFT = 3;
  localparam int unsigned DONE_SHIFT = 4;

  typedef struct packed {
    logic [1:0] projected_bias;
    logic [1:0] cap_size;
    logic ch3_en;
    logic [1:0] detection_level_trim;
    logic projected;
  } frontend_cfg_t;

  typedef struct packed {
    logic [7:0] comp;
    logic [3:0] mult;
    logic [11:0] baseline;
  } chan_word_t;

  typedef struct packed {
    logic [1:0] channel;
    logic [11:0] count;
  } sample_t;

  typedef struct packed {
    logic [1:0] channel;
    logic [3:0] mult;
    logic [7:0] comp;
  } setting_t;

  typedef enum logic {P_IDLE = 1'b0, P_EVAL = 1'b1} proc_state_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_AACK = 3'b010, I_WR = 3'b011,
    I_WACK = 3'b100, I_RD = 3'b101, I_RACK = 3'b110
  } i2c_state_t;

endpackage : cap_sense_pkg

// file: src/chan_state_mem.sv
// per-channel state memory: baseline, multiplier and compensation, registered read
`timescale 1ns/1ps
module chan_state_mem
  import cap_sense_pkg::*;
(
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire chan_word_t wr_data,
  input wire logic rd_en,
  input wire logic [1:0] rd_addr,
  output chan_word_t rd_data
);

  chan_word_t mem [0:3];

  // no reset: the owner tracks which words have been written
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : chan_state_mem

// file: src/cap_sense_detect_autotune.sv
// baseline tracking, event detection, auto tuning and serial/apb status port
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
// How it works
// - each channel keeps a 12-bit drifting baseline, readable as high and low byte
// - self mode: event when count is below baseline minus threshold
// - projected mode: event when count is above baseline plus threshold
// - channel 0 uses proximity threshold, channels 1-3 their touch thresholds
// - tuning on after reset, off only when tuning-off and partial bits both set
// - tuning-busy flag stands for the whole tuning sequence
// - tuning target is target register times 8, reached by compensation
// - partial bit clear: multiplier steps up to reach base before compensation
// - partial bit set: host multiplier kept, only compensation adjusted
// - multiplier phase touches multiplier only, never cap size or bias
// - count outside target plus or minus one eighth starts re-tuning
// - host redo bit starts tuning and is cleared once tuning starts
// - noise-detect bit enables the interference detector, trim sets its level
// - noisy samples neither update baseline nor decide events
// - interference raises the noise flag in system flags
// - serial slave answers only its single fixed 7-bit address
// - event mode by default, event-mode-off bit disables it
// - only masked-in events request communication; all enabled after reset
// - polled transfers work on data and clock lines alone
// - reset indicator reads 1 after any reset, cleared by writing ack bit
// - watchdog resets the core after a quiet period on the serial port
// - ready line low when ready, high during conversions
// - own address not acknowledged during conversions
module cap_sense_detect_autotune
  import cap_sense_pkg::*;
#(
  parameter int unsigned WDT_TIME_US = 100000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic ready_n,
  input wire logic rf_noise_in,
  input wire logic frontend_busy,
  input wire logic sample_valid,
  input wire sample_t sample,
  output logic setting_valid,
  output setting_t setting,
  output frontend_cfg_t frontend_cfg,
  output logic noise_detect_en,
  output logic wdt_reset
);

  localparam int unsigned WDT_TICKS = WDT_TIME_US / TICK_TIME_US;

  // core reset also fires from the watchdog; wdt_reset is a flop, so no glitch
  logic core_rst_n;
  assign core_rst_n = presetn & ~wdt_reset;

  // registers
  logic [7:0] ps0, ps1, tgt0, tgtt, pth, base_value, user_mult;
  logic [7:0] tth [1:3];
  logic [3:0] event_mask;
  logic [1:0] view_channel;
  logic [11:0] view_baseline, view_count;
  logic show_reset, flag_a, tuning_busy, pending;
  logic [3:0] events, seeded, tune_done, mult_done;
  logic [7:0] system_flags;

  // synchronisers
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, rf_s1, rf_s2;

  // processing
  proc_state_t pst;
  sample_t smp;
  logic smp_noise;
  chan_word_t mem_rdata, old_word, new_word;
  logic eval, hit, out_win, ch_done, nmd, tune_en, tune_start, converting;
  logic [3:0] active;
  logic [12:0] cnt13, bl13, thr13, tgt13, win13, band13;
  logic signed [12:0] diff, filt;

  // bus side
  logic [7:0] apb_idx, wr_idx, wr_data, i2c_widx, i2c_wdata, i2c_rbyte, ptr, sh;
  logic apb_mapped, apb_we, wr_en, i2c_we, comms_ok, i2c_end, rw, first;
  logic [3:0] bit_cnt;
  i2c_state_t ist;
  logic scl_rise, scl_fall, i_start, i_stop;

  // watchdog
  logic [7:0] div;
  logic tick;
  logic [31:0] wdt_cnt;

  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    case (idx)
      R_SYS: reg_read = system_flags;
      R_EVT: reg_read = {4'h0, events};
      R_PS0: reg_read = ps0 | (8'(show_reset) << PS0_SHOW_RESET);
      R_PS1: reg_read = ps1;
      R_CFG: reg_read = frontend_cfg;
      R_TGT0: reg_read = tgt0;
      R_TGTT: reg_read = tgtt;
      R_PTH: reg_read = pth;
      R_TTH1: reg_read = tth[1];
      R_TTH2: reg_read = tth[2];
      R_TTH3: reg_read = tth[3];
      R_BASE: reg_read = base_value;
      R_EMASK: reg_read = {4'h0, event_mask};
      R_MULT: reg_read = user_mult;
      R_VIEW: reg_read = {6'h00, view_channel};
      R_BLH: reg_read = {4'h0, view_baseline[11:8]};
      R_BLL: reg_read = view_baseline[7:0];
      R_CNTH: reg_read = {4'h0, view_count[11:8]};
      R_CNTL: reg_read = view_count[7:0];
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  always_comb begin
    system_flags = 8'h00;
    system_flags[SYS_BUSY] = tuning_busy;
    system_flags[SYS_NOISE] = flag_a;
    system_flags[SYS_PROJ] = frontend_cfg.projected;
    system_flags[SYS_RESET] = show_reset;
  end

  // two flops on every pin before anything looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      rf_s1 <= 1'b0;
      rf_s2 <= 1'b0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      rf_s1 <= rf_noise_in;
      rf_s2 <= rf_s1;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign i_start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  assign i_stop = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

  // apb slave: no wait states; read data are registered in the setup cycle
  assign apb_idx = {2'b00, paddr[7:2]};
  assign apb_mapped = apb_idx < REG_COUNT;
  assign apb_we = psel & penable & pready & pwrite & apb_mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata <= {24'h00_0000, reg_read(apb_idx)};
        pslverr <= ~apb_mapped;
      end
    end
  end

  // apb wins a same-cycle collision with a serial write
  assign wr_en = apb_we | i2c_we;
  assign wr_idx = apb_we ? apb_idx : i2c_widx;
  assign wr_data = apb_we ? pwdata[7:0] : i2c_wdata;

  assign tune_en = ~(ps1[PS1_TUNE_OFF] & ps0[PS0_PARTIAL]);

  // control registers
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ps0 <= PS0_RST;
      ps1 <= PS1_RST;
      frontend_cfg <= CFG_RST;
      tgt0 <= TGT0_RST;
      tgtt <= TGTT_RST;
      pth <= PTH_RST;
      tth[1] <= TTH_RST;
      tth[2] <= TTH_RST;
      tth[3] <= TTH_RST;
      base_value <= BASE_RST;
      event_mask <= EMASK_RST;
      user_mult <= {4'h0, MULT_RST};
      view_channel <= 2'b00;
    end else begin
      if (tune_start) begin
        ps0[PS0_REDO] <= 1'b0;
      end
      // a host write in the start cycle lands after the clear, so it is kept
      if (wr_en) begin
        case (wr_idx)
          R_PS0: ps0 <= wr_data & PS0_WMASK;
          R_PS1: ps1 <= wr_data & PS1_WMASK;
          R_CFG: frontend_cfg <= wr_data;
          R_TGT0: tgt0 <= wr_data;
          R_TGTT: tgtt <= wr_data;
          R_PTH: pth <= wr_data;
          R_TTH1: tth[1] <= wr_data;
          R_TTH2: tth[2] <= wr_data;
          R_TTH3: tth[3] <= wr_data;
          R_BASE: base_value <= wr_data;
          R_EMASK: event_mask <= wr_data[3:0];
          R_MULT: user_mult <= {4'h0, wr_data[3:0]};
          R_VIEW: view_channel <= wr_data[1:0];
          default: ;
        endcase
      end
    end
  end

  assign noise_detect_en = ps1[PS1_NOISE_EN];

  // reset indicator: set by any reset of the core, cleared by the ack bit
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      show_reset <= 1'b1;
    end else if (wr_en && wr_idx == R_PS0 && wr_data[PS0_ACK_RESET]) begin
      show_reset <= 1'b0;
    end
  end

  // sample capture and evaluation
  assign eval = (pst == P_EVAL);
  assign converting = frontend_busy | eval;
  assign active = {frontend_cfg.ch3_en, 3'b111};

  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pst <= P_IDLE;
      smp <= '0;
      smp_noise <= 1'b0;
    end else begin
      unique case (pst)
        P_IDLE: if (sample_valid) begin
          smp <= sample;
          smp_noise <= ps1[PS1_NOISE_EN] & rf_s2;
          pst <= P_EVAL;
        end
        P_EVAL: pst <= P_IDLE;
      endcase
    end
  end

  chan_state_mem u_mem (
    .pclk(pclk),
    .wr_en(eval),
    .wr_addr(smp.channel),
    .wr_data(new_word),
    .rd_en(pst == P_IDLE && sample_valid),
    .rd_addr(sample.channel),
    .rd_data(mem_rdata)
  );

  // comparison, filter and tuning step for the sample under evaluation
  always_comb begin
    old_word = mem_rdata;
    if (!seeded[smp.channel]) begin
      old_word = '{comp: 8'h00, mult: MULT_RST, baseline: smp.count};
    end
    cnt13 = {1'b0, smp.count};
    bl13 = {1'b0, old_word.baseline};
    thr13 = {5'h00, (smp.channel == 2'd0) ? pth : tth[smp.channel]};
    tgt13 = {2'b00, (smp.channel == 2'd0) ? tgt0 : tgtt, 3'b000};
    win13 = tgt13 >> RETUNE_SHIFT;
    band13 = tgt13 >> DONE_SHIFT;
    if (frontend_cfg.projected) begin
      hit = cnt13 > bl13 + thr13;
    end else begin
      hit = cnt13 + thr13 < bl13;
    end
    out_win = (cnt13 > tgt13 + win13) || (cnt13 + win13 < tgt13);
    diff = $signed(cnt13) - $signed(bl13);
    filt = $signed(bl13) + (diff >>> FILTER_SHIFT);
    new_word = old_word;
    ch_done = 1'b0;
    nmd = mult_done[smp.channel];
    if (smp_noise) begin
      new_word = old_word;
    end else if (tuning_busy && active[smp.channel]) begin
      new_word.baseline = smp.count;
      if (ps0[PS0_PARTIAL]) begin
        new_word.mult = user_mult[3:0];
        nmd = 1'b1;
      end
      if (!nmd) begin
        // only the multiplier moves here; cap size and bias stay as configured
        if (cnt13 < {5'h00, base_value} && old_word.mult != 4'hF) begin
          new_word.mult = old_word.mult + 4'h1;
        end else begin
          nmd = 1'b1;
        end
      end else if (cnt13 > tgt13 + band13 && old_word.comp != 8'hFF) begin
        new_word.comp = old_word.comp + 8'h01;
      end else if (cnt13 + band13 < tgt13 && old_word.comp != 8'h00) begin
        new_word.comp = old_word.comp - 8'h01;
      end else begin
        ch_done = 1'b1;
      end
    end else begin
      new_word.baseline = filt[11:0];
    end
  end

  assign tune_start = tune_en & ~tuning_busy & (ps0[PS0_REDO]
    | (eval & ~smp_noise & out_win & active[smp.channel] & seeded[smp.channel]));

  // tuning sequence: busy from start until every active channel has settled
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tuning_busy <= 1'b1;
      tune_done <= 4'h0;
      mult_done <= 4'h0;
    end else if (!tune_en) begin
      tuning_busy <= 1'b0;
    end else if (tune_start) begin
      tuning_busy <= 1'b1;
      tune_done <= 4'h0;
      mult_done <= 4'h0;
    end else if (eval && tuning_busy) begin
      tune_done[smp.channel] <= tune_done[smp.channel] | ch_done;
      mult_done[smp.channel] <= nmd;
      if (((tune_done | (4'(ch_done) << smp.channel)) | ~active) == 4'hF) begin
        tuning_busy <= 1'b0;
      end
    end
  end

  // events, noise flag and the channel view
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      events <= 4'h0;
      seeded <= 4'h0;
      flag_a <= 1'b0;
      view_baseline <= 12'h000;
      view_count <= 12'h000;
    end else if (eval) begin
      seeded[smp.channel] <= 1'b1;
      if (ps1[PS1_NOISE_EN]) begin
        flag_a <= smp_noise;
      end
      if (!tuning_busy && !smp_noise) begin
        events[smp.channel] <= hit;
      end
      if (smp.channel == view_channel) begin
        view_baseline <= new_word.baseline;
        view_count <= smp.count;
      end
    end
  end

  // pass the new tuning settings of the channel to the front end
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      setting_valid <= 1'b0;
      setting <= '0;
    end else begin
      setting_valid <= eval;
      if (eval) begin
        setting <= '{channel: smp.channel, mult: new_word.mult, comp: new_word.comp};
      end
    end
  end

  // communication request; a new event beats the clear by the end of a transfer
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pending <= 1'b0;
      ready_n <= 1'b1;
    end else begin
      if (ps1[PS1_EVT_OFF]) begin
        pending <= 1'b0;
      end else if (eval && !tuning_busy && !smp_noise && (hit != events[smp.channel])
                   && event_mask[smp.channel]) begin
        pending <= 1'b1;
      end else if (i2c_end) begin
        pending <= 1'b0;
      end
      ready_n <= converting | (~ps1[PS1_EVT_OFF] & ~pending);
    end
  end

  always_comb i2c_rbyte = reg_read(ptr); // always_comb also wakes on the registers read inside the function

  // serial slave; sampled at 125 MHz, so any bus rate up to 400 kbit/s is caught
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ist <= I_IDLE;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      i2c_we <= 1'b0;
      i2c_widx <= 8'h00;
      i2c_wdata <= 8'h00;
      comms_ok <= 1'b0;
      i2c_end <= 1'b0;
    end else begin
      i2c_we <= 1'b0;
      comms_ok <= 1'b0;
      i2c_end <= 1'b0;
      if (i_start) begin
        ist <= I_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (i_stop) begin
        i2c_end <= (ist != I_IDLE) && (ist != I_ADDR);
        ist <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (ist)
          I_ADDR, I_WR: begin
            sh <= {sh[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end
          I_RACK: ist <= sda_s2 ? I_IDLE : I_AACK;
          I_IDLE, I_AACK, I_WACK, I_RD: ;
        endcase
      end else if (scl_fall) begin
        unique case (ist)
          I_ADDR: if (bit_cnt == 4'h8) begin
            // no ack while converting; the ready line need not be watched
            if (sh[7:1] == DEV_ADDR && !converting) begin
              sda_oe <= 1'b1;
              rw <= sh[0];
              first <= ~sh[0] | first;
              comms_ok <= 1'b1;
              ist <= I_AACK;
            end else begin
              ist <= I_IDLE;
            end
          end
          I_AACK: if (rw) begin
            sh <= i2c_rbyte;
            sda_oe <= ~i2c_rbyte[7];
            bit_cnt <= 4'h1;
            ptr <= ptr + 8'h01;
            ist <= I_RD;
          end else begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            ist <= I_WR;
          end
          I_WR: if (bit_cnt == 4'h8) begin
            sda_oe <= 1'b1;
            first <= 1'b0;
            ist <= I_WACK;
            if (first) begin
              ptr <= sh;
            end else begin
              i2c_we <= 1'b1;
              i2c_widx <= ptr;
              i2c_wdata <= sh;
              ptr <= ptr + 8'h01;
            end
          end
          I_WACK: begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            ist <= I_WR;
          end
          I_RD: if (bit_cnt == 4'h8) begin
            sda_oe <= 1'b0;
            ist <= I_RACK;
          end else begin
            sda_oe <= ~sh[6];
            sh <= {sh[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
          I_IDLE, I_RACK: ;
        endcase
      end
    end
  end

  // watchdog on its own reset so that it can reset the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 8'h00;
      tick <= 1'b0;
      wdt_cnt <= 32'h0000_0000;
      wdt_reset <= 1'b0;
    end else begin
      tick <= (div == 8'(TICK_CYCLES - 1));
      div <= (div == 8'(TICK_CYCLES - 1)) ? 8'h00 : div + 8'h01;
      wdt_reset <= 1'b0;
      if (comms_ok || ps1[PS1_WDT_OFF] || wdt_reset) begin
        wdt_cnt <= 32'h0000_0000;
      end else if (tick) begin
        if (wdt_cnt == WDT_TICKS - 1) begin
          wdt_reset <= 1'b1;
          wdt_cnt <= 32'h0000_0000;
        end else begin
          wdt_cnt <= wdt_cnt + 32'h0000_0001;
        end
      end
    end
  end

endmodule : cap_sense_detect_autotune

// file: tb/cap_sense_detect_autotune_assertions.sv
// port checker for the sense post-processor
`timescale 1ns/1ps
module csd_chk
  import cap_sense_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sda_out,
  input wire logic ready_n,
  input wire logic frontend_busy,
  input wire logic sample_valid,
  input wire sample_t sample,
  input wire logic setting_valid,
  input wire setting_t setting,
  input wire frontend_cfg_t frontend_cfg,
  input wire logic noise_detect_en,
  input wire logic wdt_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed apb write; a core reset may also move the config
  wire wr = psel && penable && pready && pwrite;
  eval_time_a: assert property (sample_valid && !$past(sample_valid) && !wdt_reset |-> ##2 setting_valid)
    else $error("no setting two cycles after a sample");
  set_chan_a: assert property (setting_valid |-> setting.channel == $past(sample.channel, 2))
    else $error("setting for the wrong channel");
  busy_ready_a: assert property (frontend_busy |=> ready_n)
    else $error("ready low while converting");
  wdt_pulse_a: assert property (wdt_reset |=> !wdt_reset)
    else $error("watchdog pulse too long");
  noise_en_a: assert property (wr && paddr == 8'h0C |=> noise_detect_en == $past(pwdata[0]))
    else $error("detector enable not taken");
  cfg_hold_a: assert property (!wr && !wdt_reset |=> $stable(frontend_cfg) || wdt_reset)
    else $error("config changed by itself");
  bad_addr_a: assert property (psel && penable && pready && paddr >= 8'h4C |-> pslverr)
    else $error("unmapped access not refused");
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  cover property (sample_valid);
  cover property (wdt_reset);
  cover property (pslverr);
endmodule : csd_chk

// file: tb/i2c_host_model.sv
// serial host: start, address byte msb first, ack clock, stop
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic pclk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  // 81 cycles a step, three steps a bit: about 514 kbit/s, above 400 kbit/s
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    @(posedge pclk);
    scl <= c;
    sda <= d;
    repeat (80) @(posedge pclk);
  endtask : step
  // data moves only while the clock is low, so no false start or stop
  task automatic xfer(input logic [7:0] b, output logic ack);
    step(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, sda);
      step(1'b0, b[i]);
      step(1'b1, b[i]);
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    ack = !sda_w;
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : xfer
endmodule : i2c_host_model

// file: tb/cap_sense_detect_autotune_tb_top.sv
// self-checking bench for the sense post-processor
`timescale 1ns/1ps
module cap_sense_detect_autotune_tb_top;
  import cap_sense_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl, h_sda, sda_out, sda_oe, ready_n, ack, setting_valid, noise_detect_en, wdt_reset;
  logic rf_noise_in = 1'b0, frontend_busy = 1'b0, sample_valid = 1'b0;
  sample_t sample = '0;
  setting_t setting;
  frontend_cfg_t frontend_cfg;
  int fails = 0, checked = 0, bl, c;
  // pulled-up data line: either party may only pull it low
  wire sda_w = h_sda & ~sda_oe;
  always #4 pclk = ~pclk;
  cap_sense_detect_autotune #(.WDT_TIME_US(20)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe, .ready_n, .rf_noise_in,
    .frontend_busy, .sample_valid, .sample, .setting_valid, .setting, .frontend_cfg, .noise_detect_en, .wdt_reset);
  i2c_host_model host (.pclk, .sda_w, .scl, .sda(h_sda));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // setup then access, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rdc
  task automatic smp(input logic [11:0] x);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample <= '{2'd1, x};
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : smp
  // model keeps the channel 1 baseline with the same drift filter
  task automatic ev(input int x, input logic [7:0] e);
    smp(x[11:0]);
    bl += (x - bl) >>> 4;
    rdc(R_EVT, e);
  endtask : ev
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    c = $urandom(71);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(R_SYS, 8'h81);
    rdc(R_EMASK, 8'h0F);
    apb(1'b0, 8'h13, 8'h00);
    chk(pslverr, 1'b1);
    apb(1'b1, R_PS0, 8'h40);
    rdc(R_SYS, 8'h01);
    $display("test reset done");
    for (int n = 0; n < 3000 && wdt_reset !== 1'b1; n++) @(posedge pclk);
    rdc(R_SYS, 8'h81);
    apb(1'b1, R_PS1, 8'h80);
    apb(1'b1, R_VIEW, 8'h01);
    $display("test watchdog done");
    c = 12'h400 + $urandom % 256;
    bl = c;
    smp(c[11:0]);
    chk(32'(setting), {2'd1, MULT_RST, 8'h00});
    smp(c[11:0]);
    chk(32'(setting), {2'd1, MULT_RST, 8'h01});
    apb(1'b1, R_PS0, 8'h08);
    apb(1'b1, R_PS1, 8'h82);
    rdc(R_SYS, 8'h80);
    rdc(R_BLH, 8'(c >> 8));
    rdc(R_BLL, 8'(c));
    ev(bl - 16, 8'h00);
    ev(bl - 17, 8'h02);
    chk(ready_n, 1'b0);
    apb(1'b1, R_PS1, 8'h83);
    rf_noise_in <= 1'b1;
    repeat (4) @(posedge pclk);
    smp(12'hFFF);
    rdc(R_SYS, 8'h82);
    rdc(R_BLL, 8'(bl));
    rf_noise_in <= 1'b0;
    apb(1'b1, R_CFG, 8'h01);
    ev(bl + 16, 8'h00);
    ev(bl + 17, 8'h02);
    rdc(R_SYS, 8'h84);
    apb(1'b1, R_PS1, 8'h80);
    apb(1'b1, R_PS0, 8'h18);
    rdc(R_PS0, 8'h88);
    rdc(R_SYS, 8'h85);
    $display("test detect done");
    // own address, a wrong one, then own address while converting
    for (int k = 0; k < 3; k++) begin
      frontend_busy <= (k == 2);
      host.xfer({DEV_ADDR + 7'(k == 1), 1'b0}, ack);
      chk(ack, k == 0);
    end
    frontend_busy <= 1'b0;
    $display("test serial done");
    results();
  end
  // hang guard, well above the roughly 10200 cycles of the tests
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    results();
  end
endmodule : cap_sense_detect_autotune_tb_top
bind cap_sense_detect_autotune csd_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .sda_out, .ready_n, .frontend_busy, .sample_valid, .sample, .setting_valid, .setting, .frontend_cfg,
  .noise_detect_en, .wdt_reset);
